// ==== logic/lec_control.sv ====
`timescale 1ns/1ps
// How it works
// - Register 71 reports engine 1 map of outputs one to eight, reset zero.
// - Register 72: bit 7 engine 2 on general output, bit 0 on output nine.
// - Register 73 reports engine 2 map of outputs one to eight.
// - Register 74: bit 7 engine 3 on general output, bit 0 on output nine.
// - Register 75 reports engine 3 map of outputs one to eight.
// - Chip enable is bit 6 of register 00, reset zero; zero means standby.
// - Standby blocks writes to 00 bits 5:0, PWM 16-1E and counters 37-39.
// - Setting chip enable runs a startup count, then normal mode.
// - Engine 1 run bits at 5:4, reset 00; start address from register 37.
// - Code 00 finishes current instruction and stops; counter access only then.
// - Code 01 runs one instruction, advances counter, clears field to 00.
// - Code 10 runs continuously from the current counter.
// - Code 11 runs one instruction without advancing, clears field to 00.
// - Run bits act only while the engine's mode field is run.
// - Counter wraps to zero after its upper limit.
module lec_control #(
   parameter int PC_W = 8,
   parameter logic [PC_W-1:0] PC_MAX = PC_W'(lec_pkg::PC_MAX_DEFAULT),
   parameter int STARTUP = lec_pkg::STARTUP_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Instruction unit
   input wire logic [2:0] instr_done_i,
   output logic [2:0] instr_req_o,
   output logic [3*PC_W-1:0] instr_addr_o,
   // Output mapping from running programs
   input wire logic [2:0] map_load_i,
   input wire logic [29:0] map_value_i,
   // Chip status and PWM levels
   output logic power_up_o,
   output logic chip_ready_o,
   output logic [71:0] pwm_level_o
);

   localparam int NE = lec_pkg::NUM_ENGINES;

   logic chip_en_r;
   logic [1:0] exec_r [NE];
   logic [1:0] mode_r [NE];
   logic [7:0] pwm_r [lec_pkg::NUM_PWM];
   logic [lec_pkg::MAP_W-1:0] map_r [NE];
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;

   logic wr_en;
   logic wr_enable_reg;
   logic wr_mode_reg;
   logic pwm_hit;
   logic [3:0] pwm_idx;
   logic any_load;
   logic chip_ready;
   logic [NE-1:0] run_ok;
   logic [NE-1:0] abort;
   logic [NE-1:0] load_mode;
   logic [NE-1:0] pc_wr;
   logic [NE-1:0] held;
   logic [NE-1:0] exec_clear;
   logic [PC_W-1:0] pc [NE];

   function automatic int field_lsb(input int e);
      field_lsb = lec_pkg::ENG1_FIELD_LSB - lec_pkg::FIELD_STEP * e;
   endfunction

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   assign wr_en = ce_i && reg_wr_i;
   assign wr_enable_reg = wr_en && (reg_addr_i == lec_pkg::ADDR_ENABLE);
   assign wr_mode_reg = wr_en && (reg_addr_i == lec_pkg::ADDR_MODE);
   assign pwm_hit = in_range(reg_addr_i, lec_pkg::ADDR_PWM_FIRST, lec_pkg::ADDR_PWM_LAST);
   assign pwm_idx = 4'(reg_addr_i - lec_pkg::ADDR_PWM_FIRST);

   // Chip enable bit
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         chip_en_r <= 1'b0;
      else if (ce_i)
      begin
         if (wr_enable_reg)
            chip_en_r <= reg_wdata_i[lec_pkg::CHIP_EN_POS];
      end
   end

   lec_startup #(
      .CYCLES(STARTUP)
   ) u_startup (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .chip_en_i(chip_en_r),
      .power_up_o(power_up_o),
      .ready_o(chip_ready)
   );

   assign chip_ready_o = chip_ready;

   // Execution fields; an accepted write beats the engine's own clear
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int e = 0; e < NE; e++)
            exec_r[e] <= lec_pkg::EXEC_HOLD;
      end
      else if (ce_i)
      begin
         for (int e = 0; e < NE; e++)
         begin
            if (wr_enable_reg && chip_en_r)
               exec_r[e] <= reg_wdata_i[field_lsb(e) +: 2];
            else if (exec_clear[e])
               exec_r[e] <= lec_pkg::EXEC_HOLD;
         end
      end
   end

   // Operating modes; load only entered from disabled
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int e = 0; e < NE; e++)
            mode_r[e] <= lec_pkg::MODE_DISABLED;
      end
      else if (ce_i)
      begin
         for (int e = 0; e < NE; e++)
         begin
            if (wr_mode_reg)
            begin
               if (reg_wdata_i[field_lsb(e) +: 2] != lec_pkg::MODE_LOAD ||
                   mode_r[e] == lec_pkg::MODE_DISABLED ||
                   mode_r[e] == lec_pkg::MODE_LOAD)
                  mode_r[e] <= reg_wdata_i[field_lsb(e) +: 2];
            end
         end
      end
   end

   // PWM level registers
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < lec_pkg::NUM_PWM; i++)
            pwm_r[i] <= lec_pkg::BYTE_RESET;
      end
      else if (ce_i)
      begin
         if (wr_en && pwm_hit && chip_en_r)
            pwm_r[pwm_idx] <= reg_wdata_i;
      end
   end

   // Mapping status
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int e = 0; e < NE; e++)
            map_r[e] <= lec_pkg::MAP_RESET;
      end
      else if (ce_i)
      begin
         for (int e = 0; e < NE; e++)
         begin
            if (map_load_i[e])
               map_r[e] <= map_value_i[lec_pkg::MAP_W*e +: lec_pkg::MAP_W];
         end
      end
   end

   // While any engine loads, all engines hold after the current instruction
   assign any_load = |load_mode;

   genvar g;
   generate
      for (g = 0; g < NE; g++)
      begin : g_eng
         assign load_mode[g] = (mode_r[g] == lec_pkg::MODE_LOAD);
         assign run_ok[g] = chip_ready && (mode_r[g] == lec_pkg::MODE_RUN) && !any_load;
         assign abort[g] = (mode_r[g] != lec_pkg::MODE_RUN);
         assign pc_wr[g] = wr_en && chip_en_r &&
            (reg_addr_i == 8'(lec_pkg::ADDR_PC_FIRST + g));

         lec_engine #(
            .PC_W(PC_W),
            .PC_MAX(PC_MAX)
         ) u_engine (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .ce_i(ce_i),
            .run_ok_i(run_ok[g]),
            .abort_i(abort[g]),
            .load_mode_i(load_mode[g]),
            .exec_i(exec_r[g]),
            .pc_wr_i(pc_wr[g]),
            .pc_wdata_i(reg_wdata_i[PC_W-1:0]),
            .instr_done_i(instr_done_i[g]),
            .instr_req_o(instr_req_o[g]),
            .pc_o(pc[g]),
            .held_o(held[g]),
            .exec_clear_o(exec_clear[g])
         );

         assign instr_addr_o[PC_W*g +: PC_W] = pc[g];
      end
      for (g = 0; g < lec_pkg::NUM_PWM; g++)
      begin : g_pwm
         assign pwm_level_o[8*g +: 8] = pwm_r[g];
      end
   endgenerate

   // Read multiplexer; unmapped addresses read zero
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (reg_addr_i == lec_pkg::ADDR_ENABLE)
      begin
         rdata_nxt[lec_pkg::CHIP_EN_POS] = chip_en_r;
         for (int e = 0; e < NE; e++)
            rdata_nxt[field_lsb(e) +: 2] = exec_r[e];
      end
      else if (reg_addr_i == lec_pkg::ADDR_MODE)
      begin
         for (int e = 0; e < NE; e++)
            rdata_nxt[field_lsb(e) +: 2] = mode_r[e];
      end
      else if (pwm_hit)
         rdata_nxt = pwm_r[pwm_idx];
      else
      begin
         for (int e = 0; e < NE; e++)
         begin
            if (reg_addr_i == 8'(lec_pkg::ADDR_PC_FIRST + e) && held[e])
               rdata_nxt[PC_W-1:0] = pc[e];
            if (reg_addr_i == 8'(lec_pkg::ADDR_MAP_FIRST + 2 * e))
            begin
               rdata_nxt[lec_pkg::MAP_GPO_POS] = map_r[e][9];
               rdata_nxt[lec_pkg::MAP_OUT9_POS] = map_r[e][8];
            end
            if (reg_addr_i == 8'(lec_pkg::ADDR_MAP_FIRST + 2 * e + 1))
               rdata_nxt = map_r[e][7:0];
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end
      else if (ce_i)
      begin
         rvalid_r <= reg_rd_i;
         if (reg_rd_i)
            rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign reg_rvalid_o = rvalid_r;

endmodule

// ==== logic/lec_pkg.sv ====
package lec_pkg;

   // Register byte addresses
   localparam logic [7:0] ADDR_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_MODE = 8'h01;
   localparam logic [7:0] ADDR_PWM_FIRST = 8'h16;
   localparam logic [7:0] ADDR_PWM_LAST = 8'h1e;
   localparam logic [7:0] ADDR_PC_FIRST = 8'h37;
   localparam logic [7:0] ADDR_MAP_FIRST = 8'h70;
   localparam logic [7:0] ADDR_ENG1_MAP_LOW = 8'h71;
   localparam logic [7:0] ADDR_ENG2_MAP_HIGH = 8'h72;
   localparam logic [7:0] ADDR_ENG2_MAP_LOW = 8'h73;
   localparam logic [7:0] ADDR_ENG3_MAP_HIGH = 8'h74;
   localparam logic [7:0] ADDR_ENG3_MAP_LOW = 8'h75;

   // Field positions
   localparam int CHIP_EN_POS = 6;
   localparam int ENG1_FIELD_LSB = 4;
   localparam int FIELD_STEP = 2;
   localparam int MAP_GPO_POS = 7;
   localparam int MAP_OUT9_POS = 0;

   // Sizes and reset values
   localparam int NUM_ENGINES = 3;
   localparam int NUM_PWM = 9;
   localparam int MAP_W = 10;
   localparam logic [7:0] PC_MAX_DEFAULT = 8'h5f;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [9:0] MAP_RESET = 10'h000;

   // Startup sequence length
   localparam int CLK_PERIOD_NS = 10;
   localparam int STARTUP_TIME_NS = 500;
   localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      EXEC_HOLD = 2'b00,
      EXEC_STEP = 2'b01,
      EXEC_FREE = 2'b10,
      EXEC_ONCE = 2'b11
   } lec_exec_type;

   typedef enum logic [1:0] {
      MODE_DISABLED = 2'b00,
      MODE_LOAD = 2'b01,
      MODE_RUN = 2'b10,
      MODE_HALT = 2'b11
   } lec_mode_type;

endpackage

// ==== logic/lec_startup.sv ====
`timescale 1ns/1ps
module lec_startup #(
   parameter int CYCLES = lec_pkg::STARTUP_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Control
   input wire logic chip_en_i,
   // Status
   output logic power_up_o,
   output logic ready_o
);

   logic [15:0] cnt_r;
   logic power_r;
   logic ready_r;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_r <= 16'h0000;
         power_r <= 1'b0;
         ready_r <= 1'b0;
      end
      else if (ce_i)
      begin
         power_r <= chip_en_i;
         // Standby drops normal mode at once
         if (!chip_en_i)
         begin
            cnt_r <= 16'h0000;
            ready_r <= 1'b0;
         end
         else if (!ready_r)
         begin
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == 16'(CYCLES - 1))
               ready_r <= 1'b1;
         end
      end
   end

   assign power_up_o = power_r;
   assign ready_o = ready_r;

endmodule

// ==== logic/lec_engine.sv ====
`timescale 1ns/1ps
module lec_engine #(
   parameter int PC_W = 8,
   parameter logic [PC_W-1:0] PC_MAX = PC_W'(lec_pkg::PC_MAX_DEFAULT)
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Control
   input wire logic run_ok_i,
   input wire logic abort_i,
   input wire logic load_mode_i,
   input wire logic [1:0] exec_i,
   input wire logic pc_wr_i,
   input wire logic [PC_W-1:0] pc_wdata_i,
   // Instruction unit
   input wire logic instr_done_i,
   output logic instr_req_o,
   output logic [PC_W-1:0] pc_o,
   // Status
   output logic held_o,
   output logic exec_clear_o
);

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } lec_eng_state_type;

   lec_eng_state_type state_r;
   logic [1:0] cmd_r;
   logic [PC_W-1:0] pc_r;
   logic finish;

   function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] pc);
      pc_inc = (pc == PC_MAX) ? '0 : pc + 1'b1;
   endfunction

   assign finish = (state_r == ST_BUSY) && instr_done_i && !abort_i;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_r <= ST_IDLE;
         cmd_r <= lec_pkg::EXEC_HOLD;
      end
      else if (ce_i)
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (run_ok_i && exec_i != lec_pkg::EXEC_HOLD)
               begin
                  state_r <= ST_BUSY;
                  cmd_r <= exec_i;
               end
            end
            ST_BUSY:
            begin
               if (abort_i || instr_done_i)
                  state_r <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         pc_r <= '0;
      else if (ce_i)
      begin
         if (load_mode_i)
            pc_r <= '0;
         else if (held_o && pc_wr_i)
            pc_r <= pc_wdata_i;
         else if (finish && cmd_r != lec_pkg::EXEC_ONCE)
            pc_r <= pc_inc(pc_r);
      end
   end

   assign exec_clear_o = finish &&
      (cmd_r == lec_pkg::EXEC_STEP || cmd_r == lec_pkg::EXEC_ONCE);
   assign held_o = (state_r == ST_IDLE) && (exec_i == lec_pkg::EXEC_HOLD);
   assign instr_req_o = (state_r == ST_BUSY);
   assign pc_o = pc_r;

endmodule

// ==== verif/lec_control_checker.sv ====
`timescale 1ns/1ps
module lec_control_checker #(
   parameter int PC_W = 8,
   parameter logic [PC_W-1:0] PC_MAX = 8'h5f
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic reg_rvalid_o,
   // Engines
   input wire logic [2:0] instr_done_i,
   input wire logic [2:0] instr_req_o,
   input wire logic [3*PC_W-1:0] instr_addr_o,
   // Status
   input wire logic power_up_o,
   input wire logic chip_ready_o,
   input wire logic [71:0] pwm_level_o
);
   logic [PC_W-1:0] pc;
   logic go;
   logic pw;
   assign pc = instr_addr_o[PC_W-1:0];
   assign go = ce_i & instr_req_o[0] & instr_done_i[0];
   assign pw = ce_i & reg_wr_i & (reg_addr_i >= lec_pkg::ADDR_PWM_FIRST) &
      (reg_addr_i <= lec_pkg::ADDR_PWM_LAST);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_rvalid;
      ce_i & reg_rd_i |=> reg_rvalid_o;
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read not answered");
   property p_ready;
      chip_ready_o |-> power_up_o;
   endproperty
   a_ready: assert property (p_ready) else $error("ready without enable");
   property p_standby;
      !chip_ready_o && !instr_req_o[0] |=> !instr_req_o[0];
   endproperty
   a_standby: assert property (p_standby) else $error("fetch in standby");
   property p_pc_hold;
      instr_req_o[0] & ~instr_done_i[0] & ce_i |=> $stable(pc);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("counter moved mid fetch");
   property p_pc_adv;
      go |=> pc == $past(pc) || pc == ($past(pc) == PC_MAX ? '0 : $past(pc) + 1'b1);
   endproperty
   a_pc_adv: assert property (p_pc_adv) else $error("counter step wrong");
   property p_req_end;
      go |=> !instr_req_o[0];
   endproperty
   a_req_end: assert property (p_req_end) else $error("fetch not ended");
   property p_pwm_block;
      pw |=> (!power_up_o |-> $stable(pwm_level_o));
   endproperty
   a_pwm_block: assert property (p_pwm_block) else $error("level written in standby");
   property p_pwm_wr;
      pw |=> (power_up_o |->
         pwm_level_o[8*($past(reg_addr_i)-lec_pkg::ADDR_PWM_FIRST) +: 8] == $past(reg_wdata_i));
   endproperty
   a_pwm_wr: assert property (p_pwm_wr) else $error("level write lost");
endmodule

bind lec_control lec_control_checker #(.PC_W(PC_W), .PC_MAX(PC_MAX)) u_chk (
   .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rvalid_o(reg_rvalid_o), .instr_done_i(instr_done_i), .instr_req_o(instr_req_o),
   .instr_addr_o(instr_addr_o), .power_up_o(power_up_o), .chip_ready_o(chip_ready_o),
   .pwm_level_o(pwm_level_o));

// ==== verif/tb_lec_control.sv ====
`timescale 1ns/1ps
module tb_lec_control;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [2:0] done = 3'h0;
   logic [2:0] ld = 3'h0;
   logic ce = 1'b1;
   logic rv;
   logic [29:0] mv = 30'h0;
   logic [7:0] rdat;
   logic [2:0] req;
   logic [23:0] ia;
   logic pwr;
   logic rdy;
   logic [7:0] got;
   logic [9:0] v;
   int error_cnt = 0;
   int tests_run = 0;
   int n;
   // Write address, write data, read address, expected
   logic [31:0] rows [10] = '{32'h003f0000, 32'h16551600, 32'h37123700, 32'h71ff7100,
      32'h73ff7300, 32'hffaaff00, 32'h00400040, 32'h16551655, 32'h37123712, 32'h01200120};

   lec_control #(.STARTUP(2)) uut (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
      .instr_done_i(done), .instr_req_o(req), .instr_addr_o(ia), .map_load_i(ld),
      .map_value_i(mv), .power_up_o(pwr), .chip_ready_o(rdy), .pwm_level_o());

   initial forever #5 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] gv);
      tests_run++;
      if (gv !== ex)
      begin
         $display("BAD %s expected %h seen %h", nm, ex, gv);
         error_cnt++;
      end
   endtask

   task automatic wrap_up();
      if (error_cnt == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a);
      @(posedge clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      got = rdat;
      chk("rvalid", 8'h01, {7'h0, rv});
   endtask

   task automatic tick();
      @(posedge clk_i);
      #1;
      n++;
   endtask

   // One fetch: check address, finish it, check counter afterwards
   task automatic instr(input logic [7:0] ea, input logic [7:0] en);
      n = 0;
      while (req[0] !== 1'b1)
      begin
         tick();
         if (n > 30)
         begin
            chk("request", 8'h01, 8'h00);
            wrap_up();
         end
      end
      chk("fetch", ea, ia[7:0]);
      @(posedge clk_i);
      done <= 3'h1;
      @(posedge clk_i);
      done <= 3'h0;
      #1;
      chk("busy", 8'h00, {7'h0, req[0]});
      chk("counter", en, ia[7:0]);
   endtask

   task automatic quiet();
      repeat (5)
      begin
         tick();
         chk("idle", 8'h00, {7'h0, req[0]});
      end
   endtask

   initial
   begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      for (int a = 8'h70; a <= 8'h75; a++)
      begin
         rreg(8'(a));
         chk("map reset", 8'h00, got);
      end
      rreg(8'h00);
      chk("enable reset", 8'h00, got);
      foreach (rows[i])
      begin
         wreg(rows[i][31:24], rows[i][23:16]);
         rreg(rows[i][15:8]);
         chk("register", rows[i][7:0], got);
      end
      // Drop to standby, then restart
      wreg(8'h00, 8'h00);
      tick();
      chk("ready", 8'h00, {7'h0, rdy});
      chk("power", 8'h00, {7'h0, pwr});
      wreg(8'h00, 8'h40);
      n = 0;
      while (rdy !== 1'b1 && n < 30)
         tick();
      chk("startup", 8'h01, {7'h0, n >= 2 && n < 30});
      if (rdy !== 1'b1)
         wrap_up();
      @(posedge clk_i);
      mv <= {10'h3c3, 10'h15a, 10'h2a5};
      ld <= 3'h7;
      @(posedge clk_i);
      ld <= 3'h0;
      for (int e = 0; e < 3; e++)
      begin
         v = mv[10*e +: 10];
         rreg(8'(8'h70 + 2*e));
         chk("map high", {v[9], 6'h00, v[8]}, got);
         rreg(8'(8'h71 + 2*e));
         chk("map low", v[7:0], got);
      end
      // Frozen clock enable drops a level write
      @(posedge clk_i);
      ce <= 1'b0;
      wreg(8'h16, 8'haa);
      ce <= 1'b1;
      rreg(8'h16);
      chk("frozen write", 8'h55, got);
      wreg(8'h00, 8'h50);
      instr(8'h12, 8'h13);
      rreg(8'h00);
      chk("step clear", 8'h40, got);
      wreg(8'h00, 8'h70);
      instr(8'h13, 8'h13);
      rreg(8'h00);
      chk("once clear", 8'h40, got);
      // Free run, then hold while a fetch is open
      wreg(8'h00, 8'h60);
      instr(8'h13, 8'h14);
      wreg(8'h00, 8'h40);
      rreg(8'h37);
      chk("busy counter", 8'h00, got);
      instr(8'h14, 8'h15);
      quiet();
      rreg(8'h37);
      chk("held counter", 8'h15, got);
      wreg(8'h37, lec_pkg::PC_MAX_DEFAULT);
      wreg(8'h00, 8'h50);
      instr(lec_pkg::PC_MAX_DEFAULT, 8'h00);
      // Run bits ignored outside run mode
      wreg(8'h01, 8'h00);
      wreg(8'h00, 8'h50);
      quiet();
      // Reset while enabled and idle clears map and enable state
      @(posedge clk_i);
      reset_i <= 1'b1;
      @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      chk("ready after reset", 8'h00, {7'h0, rdy});
      rreg(8'h71);
      chk("map after reset", 8'h00, got);
      rreg(8'h00);
      chk("enable after reset", 8'h00, got);
      wrap_up();
   end
endmodule
